//--- design/mrsfe_top.sv
// Modbus RTU slave front end: character format, frame decode, responses and APB registers.
//
// Summary of operation
// - Every character carries exactly eight data bits, any parity.
// - Parity code 00 gives two stop bits; 04 even and 06 odd give one.
// - Only the ten listed bit rates from 7200 to 256000 baud are accepted.
// - Stored settings hold address 1-247 (5), rate (19200) and parity (04).
// - Switch value is high digit then low digit as one byte.
// - Switch 1-247 is the address, 0 takes stored; rate and parity stored for switch 0-247.
// - Switch 248-255 forces address 5, 19200 baud, even parity.
// - New settings reach the link only after a restart.
// - Read request: code 03 or 04, start address, count 1 to 7D.
// - Read answer echoes address and code, byte count twice registers, values, CRC.
// - Diagnostic 08 subfunction 0A clears all counters.
// - Subfunctions 0B, 0C, 0D return bus message, error and exception counts.
// - Subfunctions 0E, 0F, 10 return server message, no-response and NAK counts.
// - Subfunctions 11 and 12 return server busy and character overrun counts.
// - Code 65 reads the dictionary in pieces: 55 starts, AA fetches next.
// - Code 66 reads an array or record in pieces: 55 starts, AA continues.
// - Fields go high byte first; data of 65 and 66 go low byte first.
// - The link is a two-wire half-duplex differential bus.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mrsfe_params.svh"

module mrsfe_top
  import mrsfe_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  // APB slave port.
  input wire mrsfe_apb_req_s APB_REQ,
  output wire mrsfe_apb_rsp_s APB_RSP,
  // Two-wire bus transceiver.
  input wire logic RS485_RXD,
  output wire logic RS485_TXD,
  output wire logic RS485_DE,
  // Rotary switches.
  input wire logic [3:0] SWITCH_HIGH_DIGIT,
  input wire logic [3:0] SWITCH_LOW_DIGIT
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // One byte step of the frame check sequence.
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Bit period in clocks; zero marks an unsupported rate.
  function automatic logic [15:0] baud_div(input logic [31:0] b);
    logic [15:0] d;
    d = 16'h0000;
    case (b)
      32'd7200: d = 16'(`CLK_HZ / 7200);
      32'd9600: d = 16'(`CLK_HZ / 9600);
      32'd14400: d = 16'(`CLK_HZ / 14400);
      32'd19200: d = 16'(`CLK_HZ / 19200);
      32'd38400: d = 16'(`CLK_HZ / 38400);
      32'd56000: d = 16'(`CLK_HZ / 56000);
      32'd57600: d = 16'(`CLK_HZ / 57600);
      32'd115200: d = 16'(`CLK_HZ / 115200);
      32'd128000: d = 16'(`CLK_HZ / 128000);
      32'd256000: d = 16'(`CLK_HZ / 256000);
      default: d = 16'h0000;
    endcase
    return d;
  endfunction

  // Payload byte at position idx of the pending response.
  function automatic logic [7:0] rsp_byte(input mrsfe_state_s s, input logic [7:0] idx);
    logic [7:0] j;
    logic [3:0] w;
    j = idx - 8'd3;
    w = s.rsp_a[3:0] + j[4:1];
    rsp_byte = 8'h00;
    if (idx == 8'd0) begin
      rsp_byte = s.act_addr;
    end else if (idx == 8'd1) begin
      rsp_byte = s.rsp_fc;
    end else begin
      case (s.rsp_kind)
        MRSFE_RSP_READ: begin
          if (idx == 8'd2) begin
            rsp_byte = {s.rsp_v[6:0], 1'b0};
          end else begin
            rsp_byte = j[0] ? s.word[w][7:0] : s.word[w][15:8];
          end
        end
        MRSFE_RSP_DIAG: begin
          case (idx)
            8'd2: rsp_byte = s.rsp_a[15:8];
            8'd3: rsp_byte = s.rsp_a[7:0];
            8'd4: rsp_byte = s.rsp_v[15:8];
            default: rsp_byte = s.rsp_v[7:0];
          endcase
        end
        MRSFE_RSP_DICT: begin
          w = s.rsp_a[3:0] + {3'h0, j[1]};
          if (idx == 8'd2) begin
            rsp_byte = s.rsp_v[7:0];
          end else begin
            rsp_byte = j[0] ? s.word[w][15:8] : s.word[w][7:0];
          end
        end
        default: rsp_byte = s.rsp_exc;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // State and working values
  // ----------------------------------------------------------------------

  mrsfe_state_s s;
  mrsfe_state_s n;
  logic rxl;
  logic frame_end;
  logic acc;
  logic [7:0] fc;
  logic [15:0] fa;
  logic [15:0] fv;
  logic [15:0] sdiv;
  logic [7:0] b;
  logic [7:0] sub_ix;
  logic d_clr;
  logic d_busy;
  logic [3:0] d_ptr;
  mrsfe_rsp_e d_kind;
  logic [7:0] d_exc;
  logic [7:0] d_len;
  logic [15:0] d_v;

  // Outputs are bare flip-flop bits of the state record.
  assign APB_RSP = '{prdata: s.prdata, pready: s.pready, pslverr: s.pslverr};
  assign RS485_TXD = s.tx;
  assign RS485_DE = s.de;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // All behaviour is computed here from the registered copy of the state.
  always_comb begin
    n = s;
    rxl = s.rxs[1];
    frame_end = (s.rx_st == MRSFE_RX_IDLE) && (s.idle_bits == `SILENCE_BITS) && (s.len != 4'd0);
    acc = APB_REQ.psel && APB_REQ.penable;
    fc = s.rbuf[1];
    fa = {s.rbuf[2], s.rbuf[3]};
    fv = {s.rbuf[4], s.rbuf[5]};
    sub_ix = 8'(fa - `SUB_FIRST);
    sdiv = baud_div(s.st_baud);
    b = 8'h00;
    d_clr = 1'b0;
    d_busy = (s.tx_st != MRSFE_TX_IDLE) || s.rsp_go;
    d_ptr = s.ptr;
    d_kind = MRSFE_RSP_EXC;
    d_exc = `EXC_FUNC;
    d_len = `LEN_EXC;
    d_v = fv;

    // Pins pass two flip-flops before anything reads them.
    n.rxs = {s.rxs[0], RS485_RXD};
    n.sw1 = {SWITCH_HIGH_DIGIT, SWITCH_LOW_DIGIT};
    n.sw2 = s.sw1;

    // Link settings are latched only after reset or a restart request.
    if (s.load_cnt != 2'h0) begin
      n.load_cnt = s.load_cnt - 2'h1;
    end
    if (s.load_cnt == 2'h1) begin
      n.act_sw = s.sw2;
      if (s.sw2 >= `SW_FORCE) begin
        n.act_addr = `FACT_ADDR;
        n.act_baud = `FACT_BAUD;
        n.act_div = baud_div(`FACT_BAUD);
        n.act_par = 1'b1;
        n.act_odd = 1'b0;
      end else begin
        n.act_addr = (s.sw2 != 8'h00) ? s.sw2 : s.st_addr;
        if (s.sw2 == 8'h00 && (s.st_addr == 8'h00 || s.st_addr > `ADDR_MAX)) begin
          n.act_addr = `FACT_ADDR;
        end
        n.act_baud = (sdiv != 16'h0000) ? s.st_baud : `FACT_BAUD;
        n.act_div = (sdiv != 16'h0000) ? sdiv : baud_div(`FACT_BAUD);
        n.act_par = (s.st_par != `PAR_NONE);
        n.act_odd = (s.st_par == `PAR_ODD);
        if (s.st_par != `PAR_NONE && s.st_par != `PAR_EVEN && s.st_par != `PAR_ODD) begin
          n.act_par = 1'b1;
          n.act_odd = 1'b0;
        end
      end
    end

    // Bit-time tick measures line silence to find the end of a frame.
    if (s.tick == 16'h0000) begin
      n.tick = s.act_div - 16'h0001;
      if (rxl && s.rx_st == MRSFE_RX_IDLE && s.idle_bits != `SILENCE_BITS) begin
        n.idle_bits = s.idle_bits + 6'd1;
      end
    end else begin
      n.tick = s.tick - 16'h0001;
    end

    // Receiver is deaf while our own driver is on the half-duplex pair.
    if (!s.de) begin
      case (s.rx_st)
        MRSFE_RX_IDLE: begin
          if (!rxl) begin
            n.rx_st = MRSFE_RX_BIT;
            n.rx_cnt = {1'b0, s.act_div[15:1]};
            n.rx_k = 4'd0;
            n.idle_bits = 6'd0;
          end
        end
        MRSFE_RX_BIT: begin
          if (s.rx_cnt != 16'h0000) begin
            n.rx_cnt = s.rx_cnt - 16'h0001;
          end else begin
            n.rx_cnt = s.act_div - 16'h0001;
            n.rx_k = s.rx_k + 4'd1;
            if (s.rx_k == 4'd0 && rxl) begin
              n.rx_st = MRSFE_RX_IDLE;
            end else if (s.rx_k >= 4'd1 && s.rx_k <= 4'd8) begin
              n.rx_sh = {rxl, s.rx_sh[7:1]};
            end else if (s.rx_k == 4'd9 && s.act_par) begin
              if ((^{s.rx_sh, rxl}) != s.act_odd) begin
                n.frm_err = 1'b1;
              end
            end else if (s.rx_k != 4'd0) begin
              // First stop bit; a second one under no parity reads as idle line.
              n.rx_st = MRSFE_RX_IDLE;
              if (!rxl) begin
                n.frm_err = 1'b1;
              end
              if (s.len < `REQ_LEN) begin
                n.rbuf[s.len[2:0]] = s.rx_sh;
              end
              n.rx_crc = crc_upd(s.rx_crc, s.rx_sh);
              n.len = (s.len == `LEN_OVER) ? `LEN_OVER : s.len + 4'd1;
            end
          end
        end
        default: n.rx_st = MRSFE_RX_IDLE;
      endcase
    end

    // Request decode into a response plan.
    case (fc)
      `FC_RD_HOLD, `FC_RD_IN: begin
        if (s.len != `REQ_LEN || fv == 16'h0000 || fv > `REG_MAX) begin
          d_exc = `EXC_VALUE;
        end else if (({1'b0, fa} + {1'b0, fv}) > `NUM_WORDS) begin
          d_exc = `EXC_ADDR;
        end else begin
          d_kind = MRSFE_RSP_READ;
          d_len = `LEN_READ_HDR + {fv[6:0], 1'b0};
        end
      end
      `FC_DIAG: begin
        if (fa == `SUB_CLEAR) begin
          d_clr = 1'b1;
          d_kind = MRSFE_RSP_DIAG;
          d_len = `LEN_DIAG;
        end else if (fa >= `SUB_FIRST && fa <= `SUB_LAST) begin
          d_kind = MRSFE_RSP_DIAG;
          d_len = `LEN_DIAG;
          d_v = s.cnt[sub_ix[2:0]];
        end
      end
      `FC_DICT, `FC_ARRAY: begin
        if (s.rbuf[2] == `SUB_START || s.rbuf[2] == `SUB_NEXT) begin
          d_kind = MRSFE_RSP_DICT;
          d_len = `LEN_DICT;
          d_ptr = (s.rbuf[2] == `SUB_START) ? 4'h0 : s.ptr;
          d_v = {8'h00, s.rbuf[2]};
        end
      end
      default: d_kind = MRSFE_RSP_EXC;
    endcase

    // Frame end: check, count and arm the reply; a clear yields to same-cycle counts.
    if (frame_end) begin
      n.len = 4'd0;
      n.rx_crc = `CRC_INIT;
      n.frm_err = 1'b0;
      if (s.len == `LEN_OVER) begin
        n.cnt[`CNT_OVR] = s.cnt[`CNT_OVR] + 16'h0001;
      end else if (s.rx_crc != 16'h0000 || s.frm_err || s.len < `MIN_LEN) begin
        n.cnt[`CNT_CERR] = s.cnt[`CNT_CERR] + 16'h0001;
      end else begin
        if (d_clr && (s.rbuf[0] == s.act_addr || s.rbuf[0] == 8'h00)) begin
          n.cnt = '0;
        end
        n.cnt[`CNT_BUS] = n.cnt[`CNT_BUS] + 16'h0001;
        if (s.rbuf[0] == s.act_addr || s.rbuf[0] == 8'h00) begin
          n.cnt[`CNT_SRV] = n.cnt[`CNT_SRV] + 16'h0001;
          if (s.rbuf[0] == 8'h00) begin
            n.cnt[`CNT_NORSP] = n.cnt[`CNT_NORSP] + 16'h0001;
          end else if (d_busy) begin
            n.cnt[`CNT_BUSY] = n.cnt[`CNT_BUSY] + 16'h0001;
          end else begin
            n.rsp_go = 1'b1;
            n.rsp_kind = d_kind;
            n.rsp_len = d_len;
            n.rsp_exc = d_exc;
            n.rsp_a = (d_kind == MRSFE_RSP_DICT) ? {12'h000, d_ptr} : fa;
            n.rsp_v = d_v;
            n.rsp_fc = (d_kind == MRSFE_RSP_EXC) ? (fc | `FC_EXC_FLAG) : fc;
            if (d_kind == MRSFE_RSP_EXC) begin
              n.cnt[`CNT_EXC] = n.cnt[`CNT_EXC] + 16'h0001;
            end
            if (d_kind == MRSFE_RSP_DICT) begin
              n.ptr = d_ptr + 4'h2;
            end
          end
        end
      end
    end

    // Transmitter: each character is start, eight data, parity or stop, stop.
    case (s.tx_st)
      MRSFE_TX_IDLE: begin
        if (s.rsp_go) begin
          n.rsp_go = 1'b0;
          n.tx_st = MRSFE_TX_BIT;
          n.tx_idx = 8'd0;
          b = rsp_byte(s, 8'd0);
          n.tx_crc = crc_upd(`CRC_INIT, b);
          n.tx_sh = b;
          n.tx_pb = (^b) ^ s.act_odd;
          n.tx_k = 4'd0;
          n.tx_cnt = s.act_div - 16'h0001;
          n.tx = 1'b0;
          n.de = 1'b1;
        end
      end
      MRSFE_TX_BIT: begin
        if (s.tx_cnt != 16'h0000) begin
          n.tx_cnt = s.tx_cnt - 16'h0001;
        end else begin
          n.tx_cnt = s.act_div - 16'h0001;
          n.tx_k = s.tx_k + 4'd1;
          if (s.tx_k <= 4'd7) begin
            n.tx = s.tx_sh[s.tx_k[2:0]];
          end else if (s.tx_k == 4'd8) begin
            n.tx = s.act_par ? s.tx_pb : 1'b1;
          end else if (s.tx_k == 4'd9) begin
            n.tx = 1'b1;
          end else if (s.tx_idx + 8'd1 == s.rsp_len) begin
            n.tx_st = MRSFE_TX_IDLE;
            n.de = 1'b0;
          end else begin
            // Next character; the check sequence closes the frame low byte first.
            n.tx_idx = s.tx_idx + 8'd1;
            if (n.tx_idx == s.rsp_len - 8'd2) begin
              b = s.tx_crc[7:0];
            end else if (n.tx_idx == s.rsp_len - 8'd1) begin
              b = s.tx_crc[15:8];
            end else begin
              b = rsp_byte(s, n.tx_idx);
              n.tx_crc = crc_upd(s.tx_crc, b);
            end
            n.tx_sh = b;
            n.tx_pb = (^b) ^ s.act_odd;
            n.tx_k = 4'd0;
            n.tx = 1'b0;
          end
        end
      end
      default: n.tx_st = MRSFE_TX_IDLE;
    endcase

    // APB slave: one wait state, read data set with pready, writes at the completing edge.
    n.pready = 1'b0;
    n.pslverr = 1'b0; // The error flag is only meaningful while pready stands.
    if (acc && !s.pready) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = 32'h0000_0000;
      if (APB_REQ.paddr[7:6] == `OFS_WORD_WIN && APB_REQ.paddr[1:0] == 2'b00) begin
        n.prdata = {16'h0000, s.word[APB_REQ.paddr[5:2]]};
      end else if (APB_REQ.paddr >= `OFS_CNT_LO && APB_REQ.paddr <= `OFS_CNT_HI
                   && APB_REQ.paddr[1:0] == 2'b00) begin
        b = 8'(APB_REQ.paddr - `OFS_CNT_LO);
        n.prdata = {s.cnt[{b[3:2], 1'b1}], s.cnt[{b[3:2], 1'b0}]};
      end else begin
        case (APB_REQ.paddr)
          `OFS_CTRL: n.prdata = 32'h0000_0000;
          `OFS_ST_ADDR: n.prdata = {24'h000000, s.st_addr};
          `OFS_ST_BAUD: n.prdata = s.st_baud;
          `OFS_ST_PAR: n.prdata = {24'h000000, s.st_par};
          `OFS_ACT_CFG: n.prdata = {6'h00, s.act_odd, s.act_par, s.act_sw, 8'h00, s.act_addr};
          `OFS_ACT_BAUD: n.prdata = s.act_baud;
          default: n.pslverr = 1'b1;
        endcase
      end
    end
    if (acc && s.pready && APB_REQ.pwrite && !s.pslverr) begin
      if (APB_REQ.paddr[7:6] == `OFS_WORD_WIN) begin
        n.word[APB_REQ.paddr[5:2]] = APB_REQ.pwdata[15:0];
      end
      case (APB_REQ.paddr)
        `OFS_CTRL: begin
          if (APB_REQ.pwdata[`CTRL_RESTART]) begin
            n.load_cnt = `LOAD_DELAY;
          end
        end
        `OFS_ST_ADDR: n.st_addr = APB_REQ.pwdata[7:0];
        `OFS_ST_BAUD: n.st_baud = APB_REQ.pwdata;
        `OFS_ST_PAR: n.st_par = APB_REQ.pwdata[7:0];
        default: n.st_par = n.st_par;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Reset loads constants only; switches are sampled a few clocks after release.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s <= '0;
      s.load_cnt <= `LOAD_DELAY;
      s.rxs <= 2'b11;
      s.act_addr <= `FACT_ADDR;
      s.act_baud <= `FACT_BAUD;
      s.act_div <= 16'(`CLK_HZ / 19200);
      s.act_par <= 1'b1;
      s.st_addr <= `FACT_ADDR;
      s.st_baud <= `FACT_BAUD;
      s.st_par <= `PAR_EVEN;
      s.rx_crc <= `CRC_INIT;
      s.tx_crc <= `CRC_INIT;
      s.tx <= 1'b1;
    end else if (CE) begin
      s <= n;
    end
  end

endmodule
`default_nettype wire

//--- design/mrsfe_params.svh
// Offsets, field positions, reset values and timing counts of the Modbus RTU slave front end.
`ifndef MRSFE_PARAMS_SVH
`define MRSFE_PARAMS_SVH
// Timing: system clock rate and the inter-frame silence in bit times (3.5 characters).
`define CLK_HZ 100000000
`define SILENCE_BITS 6'd39
`define LOAD_DELAY 2'h3
// Frame check sequence.
`define CRC_POLY 16'ha001
`define CRC_INIT 16'hffff
// APB register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_ST_ADDR 8'h04
`define OFS_ST_BAUD 8'h08
`define OFS_ST_PAR 8'h0c
`define OFS_ACT_CFG 8'h10
`define OFS_ACT_BAUD 8'h14
`define OFS_CNT_LO 8'h18
`define OFS_CNT_HI 8'h24
`define OFS_WORD_WIN 2'b01
`define CTRL_RESTART 0
// Factory settings and parity codes.
`define FACT_ADDR 8'h05
`define FACT_BAUD 32'd19200
`define PAR_NONE 8'h00
`define PAR_EVEN 8'h04
`define PAR_ODD 8'h06
`define SW_FORCE 8'hf8
`define ADDR_MAX 8'hf7
// Function and subfunction codes.
`define FC_RD_HOLD 8'h03
`define FC_RD_IN 8'h04
`define FC_DIAG 8'h08
`define FC_DICT 8'h65
`define FC_ARRAY 8'h66
`define FC_EXC_FLAG 8'h80
`define SUB_START 8'h55
`define SUB_NEXT 8'haa
`define SUB_CLEAR 16'h000a
`define SUB_FIRST 16'h000b
`define SUB_LAST 16'h0012
`define REG_MAX 16'h007d
`define NUM_WORDS 17'd16
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
// Frame lengths in bytes.
`define MIN_LEN 4'd4
`define REQ_LEN 4'd8
`define LEN_OVER 4'd9
`define LEN_EXC 8'd5
`define LEN_DIAG 8'd8
`define LEN_DICT 8'd9
`define LEN_READ_HDR 8'd5
// Diagnostic counter slots, in subfunction order from the first one.
`define CNT_BUS 3'd0
`define CNT_CERR 3'd1
`define CNT_EXC 3'd2
`define CNT_SRV 3'd3
`define CNT_NORSP 3'd4
`define CNT_BUSY 3'd6
`define CNT_OVR 3'd7
`endif

//--- design/mrsfe_pkg.sv
// Types of the Modbus RTU slave front end.
package mrsfe_pkg;
  typedef enum logic [0:0] {MRSFE_RX_IDLE, MRSFE_RX_BIT} mrsfe_rx_e;
  typedef enum logic [0:0] {MRSFE_TX_IDLE, MRSFE_TX_BIT} mrsfe_tx_e;
  typedef enum logic [1:0] {MRSFE_RSP_READ, MRSFE_RSP_DIAG, MRSFE_RSP_EXC, MRSFE_RSP_DICT} mrsfe_rsp_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mrsfe_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mrsfe_apb_rsp_s;

  typedef struct packed {
    logic [1:0] load_cnt;
    logic [1:0] rxs;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [7:0] act_addr;
    logic [31:0] act_baud;
    logic [15:0] act_div;
    logic act_par;
    logic act_odd;
    logic [7:0] act_sw;
    logic [7:0] st_addr;
    logic [31:0] st_baud;
    logic [7:0] st_par;
    mrsfe_rx_e rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_k;
    logic [7:0] rx_sh;
    logic frm_err;
    logic [15:0] tick;
    logic [5:0] idle_bits;
    logic [3:0] len;
    logic [7:0][7:0] rbuf;
    logic [15:0] rx_crc;
    logic rsp_go;
    mrsfe_rsp_e rsp_kind;
    logic [7:0] rsp_fc;
    logic [7:0] rsp_exc;
    logic [7:0] rsp_len;
    logic [15:0] rsp_a;
    logic [15:0] rsp_v;
    logic [3:0] ptr;
    logic [7:0][15:0] cnt;
    logic [15:0][15:0] word;
    mrsfe_tx_e tx_st;
    logic [15:0] tx_cnt;
    logic [3:0] tx_k;
    logic [7:0] tx_idx;
    logic [7:0] tx_sh;
    logic tx_pb;
    logic [15:0] tx_crc;
    logic tx;
    logic de;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mrsfe_state_s;
endpackage

//--- tb/mrsfe_checker.sv
// Concurrent checks on the APB port and the line driver of the front end.
`timescale 1ns/1ps
`default_nettype none

module mrsfe_checker
  import mrsfe_pkg::*;
(
  // Clock, reset and enable.
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  // APB port.
  input wire mrsfe_apb_req_s APB_REQ,
  input wire mrsfe_apb_rsp_s APB_RSP,
  // Line driver.
  input wire logic RS485_TXD,
  input wire logic RS485_DE
);
  // ------
  // Checks
  // ------
  // One clock domain, so clocking and reset masking are declared once.
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  pready_pulse_a: assert property (APB_RSP.pready && CE |=> !APB_RSP.pready)
    else $error("ready stood longer than one cycle");
  apb_answer_a: assert property (APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready && CE
    |=> APB_RSP.pready) else $error("no answer after one wait state");
  pready_cause_a: assert property (APB_RSP.pready |-> $past(APB_REQ.psel && APB_REQ.penable))
    else $error("ready without an access phase");
  slverr_qual_a: assert property (APB_RSP.pslverr |-> APB_RSP.pready)
    else $error("error flag without ready");
  slverr_data_a: assert property (APB_RSP.pslverr |-> APB_RSP.prdata == 32'h0)
    else $error("refused read returned data");
  line_idle_a: assert property (!RS485_DE |-> RS485_TXD)
    else $error("line not idle high while released");
  // The start bit lasts a whole bit time, far more than eight clocks.
  start_width_a: assert property ($rose(RS485_DE) |-> !RS485_TXD [*8])
    else $error("reply does not open with a start bit");
  stop_level_a: assert property ($fell(RS485_DE) |-> $past(RS485_TXD))
    else $error("driver released before a stop level");

  cover property (APB_RSP.pslverr);
  cover property (APB_RSP.pready && APB_REQ.pwrite);
  cover property ($fell(RS485_DE));
endmodule

bind mrsfe_top mrsfe_checker i_mrsfe_checker (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .RS485_TXD(RS485_TXD), .RS485_DE(RS485_DE));
`default_nettype wire

//--- tb/mrsfe_master.sv
// Behavioural bus master that sends requests on the line and collects replies.
`timescale 1ns/1ps
`default_nettype none

module mrsfe_master (
  // Clock and line.
  input wire logic clk,
  input wire logic txd,
  input wire logic de,
  output var logic rxd
);
  // ----------------
  // Character timing
  // ----------------
  // Clocks per bit at 256000 baud; the block truncates the same way.
  localparam int div = 390;

  // The bias holds the released line high between frames.
  initial rxd = 1'b1;

  // Frame check word, computed here independently of the block.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  // Start, eight data bits low first, even parity, one stop.
  task automatic put_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (div) @(posedge clk);
    end
  endtask

  // Sends a frame; the check word goes low byte first.
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) put_byte(q[i]);
  endtask

  // A late, misframed or badly parity-coded character comes back unknown.
  task automatic get_byte(output logic [7:0] b);
    int n;
    n = 0;
    b = 'x;
    while (!(de === 1'b1 && txd === 1'b0) && n < 60 * div) begin
      @(posedge clk);
      n++;
    end
    if (n < 60 * div) begin
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk);
        b[i] = txd;
      end
      repeat (div) @(posedge clk);
      if (txd !== ^b) b = 'x;
      repeat (div) @(posedge clk);
      if (txd !== 1'b1) b = 'x;
    end
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench: stored settings, switch sources and one read over the line.
`timescale 1ns/1ps
`default_nettype none
`include "mrsfe_params.svh"

module tb_top
  import mrsfe_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  mrsfe_apb_req_s req = '0;
  mrsfe_apb_rsp_s rsp;
  logic rxd, txd, de;
  logic [3:0] sw_hi = 4'h0;
  logic [3:0] sw_lo = 4'h0;
  logic [32:0] r;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  mrsfe_top i_mrsfe_top (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(1'b1), .APB_REQ(req),
    .APB_RSP(rsp), .RS485_RXD(rxd), .RS485_TXD(txd), .RS485_DE(de),
    .SWITCH_HIGH_DIGIT(sw_hi), .SWITCH_LOW_DIGIT(sw_lo));
  mrsfe_master i_mrsfe_master (.clk(clk_sys), .txd(txd), .de(de), .rxd(rxd));

  // -------
  // Helpers
  // -------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; returns {pslverr, prdata} taken at the ready edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [32:0] q);
    int n;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    q = {rsp.pslverr, rsp.prdata};
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Switches settle through the synchronisers before the restart relatches them.
  task automatic restart(input logic [7:0] v);
    sw_hi <= v[7:4];
    sw_lo <= v[3:0];
    repeat (4) @(posedge clk_sys);
    apb(1'b1, `OFS_CTRL, 32'h1, r);
    repeat (8) @(posedge clk_sys);
  endtask

  // ---------
  // Scenarios
  // ---------
  task automatic test_defaults();
    apb(1'b0, `OFS_ST_ADDR, 32'h0, r);
    chk(r, `FACT_ADDR);
    apb(1'b0, `OFS_ST_BAUD, 32'h0, r);
    chk(r, `FACT_BAUD);
    apb(1'b0, `OFS_ST_PAR, 32'h0, r);
    chk(r, `PAR_EVEN);
    apb(1'b0, 8'h30, 32'h0, r);
    chk(r, 33'h1_0000_0000);
  endtask

  task automatic test_config();
    logic [7:0] sv[5] = '{8'h00, 8'ha1, 8'hf7, 8'hf8, 8'hff};
    logic [7:0] ea[5] = '{8'h11, 8'ha1, 8'hf7, `FACT_ADDR, `FACT_ADDR};
    logic [7:0] pc[3] = '{`PAR_NONE, `PAR_ODD, `PAR_EVEN};
    logic [1:0] pb[3] = '{2'b00, 2'b11, 2'b01};
    apb(1'b1, `OFS_ST_ADDR, 32'h11, r);
    apb(1'b1, `OFS_ST_BAUD, 32'd12345, r);
    restart(8'h00);
    apb(1'b0, `OFS_ACT_BAUD, 32'h0, r);
    chk(r, `FACT_BAUD);
    apb(1'b1, `OFS_ST_BAUD, 32'd256000, r);
    apb(1'b0, `OFS_ACT_BAUD, 32'h0, r);
    chk(r, `FACT_BAUD);
    for (int i = 0; i < 5; i++) begin
      restart(sv[i]);
      apb(1'b0, `OFS_ACT_CFG, 32'h0, r);
      chk({r[25:16], r[7:0]}, {2'b01, sv[i], ea[i]});
      apb(1'b0, `OFS_ACT_BAUD, 32'h0, r);
      chk(r, (sv[i] >= `SW_FORCE) ? `FACT_BAUD : 32'd256000);
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `OFS_ST_PAR, {24'h0, pc[i]}, r);
      restart(8'h00);
      apb(1'b0, `OFS_ACT_CFG, 32'h0, r);
      chk(r[25:24], pb[i]);
    end
  endtask

  // Reads register 2, a four-byte aligned position, from station 11 at 256000 baud, even parity.
  task automatic test_link();
    logic [7:0] b;
    logic [15:0] c;
    logic [7:0] exp[$];
    apb(1'b1, 8'h48, 32'h0000beef, r);
    i_mrsfe_master.send('{8'h11, `FC_RD_IN, 8'h00, 8'h02, 8'h00, 8'h01});
    exp = '{8'h11, `FC_RD_IN, 8'h02, 8'hbe, 8'hef};
    c = i_mrsfe_master.crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    foreach (exp[i]) begin
      i_mrsfe_master.get_byte(b);
      chk(b, exp[i]);
    end
    // One good frame for this station: one bus message, one server message, no errors.
    apb(1'b0, `OFS_CNT_LO, 32'h0, r);
    chk(r, 33'h0_0000_0001);
    apb(1'b0, 8'h1c, 32'h0, r);
    chk(r, 33'h0_0001_0000);
  endtask

  // -------------
  // Run and close
  // -------------
  task automatic tally_and_finish();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hung wait is cut short well after the single line frame should end.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 95000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    test_defaults();
    test_config();
    test_link();
    tally_and_finish();
  end
endmodule
`default_nettype wire
